// *** dv/ssp_ctrl_model.sv ***
// Memory-controller model on the far side of the data port.
// Assumes the bench calls its tasks from one process; pins change just after aclk rises.
module ssp_ctrl_model
   import ssp_pkg::*;
(
   input  wire logic                 aclk,
   input  wire logic [SSP_DW-1:0]    dq_out,
   input  wire logic [SSP_DW-1:0]    dq_oe,
   input  wire logic [SSP_LANES-1:0] par_out,
   output ssp_pin_t                  p
);
   timeunit 1ns;
   timeprecision 1ps;
   ssp_pin_t             c;        // Pins as the controller drives them
   ssp_wr_t              owe_q;    // Write beat owed in the next cycle
   logic                 owe_v;
   logic                 drv;
   logic [SSP_DW-1:0]    last_q;
   logic [SSP_LANES-1:0] lastp_q;
   logic [SSP_DW-1:0]    seen[$];
   logic [SSP_LANES-1:0] seen_p[$];

   // Deselected, sleep low and interleaved strap until told otherwise
   initial begin
      c = '0;
      c.cs_a_n = 1'b1;
      c.write_n = 1'b1;
      c.lane_n = '1;
      c.mode = 1'b1;
      c.sleep = 1'b0;
      owe_q = '0;
      owe_v = 1'b0;
      drv = 1'b0;
      last_q = '0;
      lastp_q = '0;
   end

   // Shared lines; nobody driving shows a changing pattern, never the old value
   always_comb begin
      p = c;
      p.dq = drv ? c.dq : (dq_oe[0] ? dq_out : ~last_q);
      p.par = drv ? c.par : (dq_oe[0] ? par_out : ~lastp_q);
   end

   // Read data is taken at the edge that ends the drive cycle
   always @(posedge aclk) begin
      last_q <= p.dq;
      lastp_q <= p.par;
      if (dq_oe[0] === 1'b1) begin
         seen.push_back(dq_out);
         seen_p.push_back(par_out);
      end
   end

   // One cycle: 0 deselect, 1 read load, 2 write load, 3 advance
   task automatic op(input int k, input logic [SSP_AW-1:0] a, input logic [SSP_DW-1:0] d,
                     input logic [SSP_LANES-1:0] pr, input logic [SSP_LANES-1:0] ln);
      @(posedge aclk);
      drv <= owe_v;
      c.dq <= owe_q.dq;
      c.par <= owe_q.par;
      c.lane_n <= owe_v ? owe_q.lane_n : '1;
      c.adv <= (k == 3);
      c.cs_a_n <= (k == 0);
      c.cs_b <= (k != 0);
      c.cs_c_n <= (k == 0);
      c.write_n <= (k != 2);
      c.addr <= a;
      owe_v <= (k == 2);
      owe_q <= '{a, d, pr, ln};
   endtask

   // Static pins: clock qualify, sleep request, burst strap
   task automatic pins(input logic q, input logic s, input logic m);
      @(posedge aclk);
      c.cqn <= q;
      c.sleep <= s;
      c.mode <= m;
   endtask
endmodule

// *** dv/ssp_top_bench.sv ***
// Self-checking bench: pin traffic through the controller model, status over AXI4-Lite.
// Assumes the hand-over latencies; waits are bounded, expectations come from a shadow memory.
module ssp_top_bench
   import ssp_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int IDL = 0;
   localparam int RD  = 1;
   localparam int WR  = 2;
   localparam int ADV = 3;
   logic                 aclk = 1'b0;
   logic                 aresetn = 1'b0;
   logic                 output_gate_n = 1'b1;
   logic                 mode = 1'b1;
   ssp_pin_t             p;
   logic [SSP_DW-1:0]    dq_out, dq_oe;
   logic [SSP_LANES-1:0] parity_lanes_out, parity_lanes_oe;
   logic                 s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic                 s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0]           s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0]          s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]           s_axi_wstrb = 4'hF;
   logic [1:0]           s_axi_bresp, s_axi_rresp;
   logic [35:0]          mem [SSP_DEPTH];  // Shadow of parity and data per word
   int                   errors = 0, n_checks = 0, cycles = 0;

   ssp_ctrl_model ssp_ctrl_model_inst (.aclk(aclk), .dq_out(dq_out), .dq_oe(dq_oe), .par_out(parity_lanes_out), .p(p));
   ssp_top ssp_top_inst (.*, .clock_qualify_n(p.cqn), .sleep_request(p.sleep), .chip_select_a_n(p.cs_a_n),
      .chip_select_b(p.cs_b), .chip_select_c_n(p.cs_c_n), .advance_or_load(p.adv), .write_n(p.write_n),
      .byte_lane_write_n(p.lane_n), .addr(p.addr), .burst_order(p.mode), .dq_in(p.dq), .parity_lanes_in(p.par));

   // 20 MHz clock
   always #25 aclk = ~aclk;

   task automatic check(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // A hang counts as a mismatch
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         errors++;
         $display("[ERR] %0t run did not finish", $time);
         finish_test();
      end
   end

   // Address and data offered together, each released when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check(s_axi_bresp === er, "register write response");
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] mk, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      check((s_axi_rdata & mk) === ed && s_axi_rresp === er, "register read");
   endtask

   // Pin cycle; a write also updates the shadow lane by lane
   task automatic op(input int k, input logic [3:0] a, input logic [31:0] d = 32'h0, input logic [3:0] ln = 4'h0);
      logic [3:0] pr;
      for (int l = 0; l < 4; l++) pr[l] = ^d[8*l +: 8];
      if (k == WR) begin
         for (int l = 0; l < 4; l++) begin
            if (!ln[l]) begin
               mem[a][32+l]     = pr[l];
               mem[a][8*l +: 8] = d[8*l +: 8];
            end
         end
      end
      ssp_ctrl_model_inst.op(k, a, d, pr, ln);
   endtask

   // Load at a, n-1 advances, expect ne driven beats in burst order
   task automatic rd_burst(input logic [3:0] a, input int n, input logic il, input int ne);
      logic [3:0] e;
      ssp_ctrl_model_inst.seen.delete();
      ssp_ctrl_model_inst.seen_p.delete();
      for (int k = 0; k < n; k++) op(k == 0 ? RD : ADV, a);
      repeat (5) op(IDL, 4'h0);
      check(ssp_ctrl_model_inst.seen.size() == ne, "driven beat count");
      for (int k = 0; k < ne && k < ssp_ctrl_model_inst.seen.size(); k++) begin
         e = {a[3:2], il ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
         check({ssp_ctrl_model_inst.seen_p[k], ssp_ctrl_model_inst.seen[k]} === mem[e], "read word");
      end
   endtask

   task automatic t_regs;
      axi_rd(SSP_STAT_ADDR, 32'h2, 32'hF, SSP_RESP_OKAY);
      axi_rd(SSP_CTRL_ADDR, 32'h0, 32'hFFFF_FFFF, SSP_RESP_OKAY);
      axi_rd(8'h08, 32'h0, 32'hFFFF_FFFF, SSP_RESP_SLVERR);
      axi_wr(SSP_STAT_ADDR, 32'hFFFF_FFFF, SSP_RESP_OKAY);
      axi_rd(SSP_STAT_ADDR, 32'h2, 32'hF, SSP_RESP_OKAY);
   endtask

   // Back-to-back writes, then a one-lane write over word 5
   task automatic t_write;
      output_gate_n <= 1'b0;
      ssp_ctrl_model_inst.seen.delete();
      for (int i = 0; i < 12; i++) op(WR, 4'(i), 32'h1357_9BDF ^ {8{4'(i)}});
      op(WR, 4'h5, 32'hDEAD_BEEF, 4'b1101);
      repeat (5) op(IDL, 4'h0);
      check(ssp_ctrl_model_inst.seen.size() == 0, "drove during write or deselect");
      rd_burst(4'h5, 1, 1'b0, 1);
   endtask

   task automatic t_gate;
      output_gate_n <= 1'b1;
      rd_burst(4'h6, 1, 1'b0, 0);
      output_gate_n <= 1'b0;
      rd_burst(4'h6, 1, 1'b0, 1);
   endtask

   // Stretch a read with clock qualify; a clocked gate would need two edges to act
   task automatic t_hold;
      int n;
      n = 0;
      op(RD, 4'h7);
      ssp_ctrl_model_inst.pins(1'b1, 1'b0, mode);
      while (dq_oe[0] !== 1'b1 && n < 10) begin
         @(posedge aclk);
         n++;
      end
      repeat (6) @(posedge aclk);
      check(dq_oe === '1 && {parity_lanes_out, dq_out} === mem[7], "stretched read lost");
      @(posedge aclk);
      output_gate_n <= 1'b1;
      #1 check(dq_oe === '0 && parity_lanes_oe === '0, "gate high still drives");
      @(posedge aclk);
      output_gate_n <= 1'b0;
      #1 check(dq_oe === '1 && parity_lanes_oe === '1, "gate low does not drive");
      ssp_ctrl_model_inst.pins(1'b0, 1'b0, mode);
      repeat (5) op(IDL, 4'h0);
   endtask

   task automatic t_burst;
      rd_burst(4'h9, 4, 1'b1, 4);
      mode = 1'b0;
      ssp_ctrl_model_inst.pins(1'b0, 1'b0, mode);
      repeat (4) @(posedge aclk);
      axi_rd(SSP_STAT_ADDR, 32'h0, 32'h2, SSP_RESP_OKAY);
      rd_burst(4'h9, 4, 1'b0, 4);
   endtask

   // Soft and pin sleep; a read refused under soft sleep, contents kept
   task automatic t_sleep;
      axi_wr(SSP_CTRL_ADDR, 32'h1, SSP_RESP_OKAY);
      repeat (6) @(posedge aclk);
      axi_rd(SSP_STAT_ADDR, 32'h1, 32'h1, SSP_RESP_OKAY);
      rd_burst(4'h5, 1, 1'b0, 0);
      axi_wr(SSP_CTRL_ADDR, 32'h0, SSP_RESP_OKAY);
      ssp_ctrl_model_inst.pins(1'b0, 1'b1, mode);
      repeat (6) @(posedge aclk);
      axi_rd(SSP_STAT_ADDR, 32'h1, 32'h1, SSP_RESP_OKAY);
      ssp_ctrl_model_inst.pins(1'b0, 1'b0, mode);
      repeat (6) @(posedge aclk);
      rd_burst(4'h5, 1, 1'b0, 1);
   endtask

   // Reset for 16 cycles, then the scenarios in turn
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      t_regs();
      t_write();
      t_gate();
      t_hold();
      t_burst();
      t_sleep();
      finish_test();
   end
endmodule

// *** logic/ssp_burst.sv ***
// Two-bit burst address sequencer, linear or interleaved.
// Load and advance act only while en, the caller's clock-qualify enable, is high.
module ssp_burst
   import ssp_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       en,
   input  wire logic       load,
   input  wire logic       advance,
   input  wire logic [1:0] start,
   input  wire logic       interleaved,
   output logic [1:0]      cnt_d,
   output logic [1:0]      cnt_q
);
   logic [1:0] base_q, base_d, step_q, step_d;

   // Next base and step; the step wraps naturally after four beats
   always_comb begin
      base_d = base_q;
      step_d = step_q;
      if (en && load) begin
         base_d = start;
         step_d = 2'h0;
      end else if (en && advance) begin
         step_d = step_q + SSP_STEP_ONE;
      end
      cnt_d = interleaved ? (base_d ^ step_d) : (base_d + step_d);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         base_q <= 2'h0;
         step_q <= 2'h0;
         cnt_q  <= 2'h0;
      end else begin
         base_q <= base_d;
         step_q <= step_d;
         cnt_q  <= cnt_d;
      end
   end

   a_burst_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
      (en && advance && !load && interleaved) |=> (cnt_q == ($past(cnt_q) ^ ($past(step_q) ^ step_q))))
      else $error("interleaved burst step wrong");
endmodule

// *** logic/ssp_fifo2.sv ***
// Two-entry buffer with valid/ready on both sides.
// Assumes a single clock; in_ready falls only when both entries hold data.
module ssp_fifo2 #(
   parameter int W = 8
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic [W-1:0] ent_q [2];
   logic [W-1:0] ent_d [2];
   logic [1:0]   cnt_q, cnt_d;
   logic         wp_q, wp_d, rp_q, rp_d;
   logic         push, pop;

   // Pointer and count bookkeeping
   always_comb begin
      push     = in_valid && in_ready;
      pop      = out_valid && out_ready;
      in_ready = (cnt_q != 2'h2);
      out_valid = (cnt_q != 2'h0);
      out_data = ent_q[rp_q];
      ent_d    = ent_q;
      if (push) ent_d[wp_q] = in_data;
      wp_d  = push ? ~wp_q : wp_q;
      rp_d  = pop ? ~rp_q : rp_q;
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 2'h0;
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         wp_q  <= wp_d;
         rp_q  <= rp_d;
      end
      ent_q <= ent_d;
   end
endmodule

// *** logic/ssp_pkg.sv ***
// Constants and types for the synchronous burst memory data-port block.
// Assumes one 20 MHz clock (aclk) and a synchronous active-low reset.
// Contract
// - Output gate low and nothing masking: data and parity lines are driven.
// - Output gate high: data and parity lines float to act as write inputs.
// - Never drive during write data cycles, the emerging cycle, or while deselected.
// - The output gate acts directly on the drivers, not through the clock.
// - An edge counts only while clock qualify is low; otherwise all state holds. The code still drains a buffered write beat into the array.
// - Clock qualify high stretches the previous cycle and does not deselect.
// - Sleep request puts the device in low power, keeping memory contents.
// - Input data lines are captured into a data register on the rising edge.
// - Read data is the word addressed at the previous rising edge.
// - Parity lanes act as data lanes, written only with their byte select.
// - Burst strap low selects linear order, high or open selects interleaved.
// - Both orders step the two low address bits and wrap after four beats.
// - Byte selects act only with a write; unselected lanes keep their contents.
package ssp_pkg;
   localparam int          SSP_AW        = 4;      // Word address width
   localparam int          SSP_DEPTH     = 16;
   localparam int          SSP_LANES     = 4;
   localparam int          SSP_LANE_W    = 8;
   localparam int          SSP_DW        = 32;
   localparam logic [7:0]  SSP_CTRL_ADDR = 8'h00;  // Control: soft sleep
   localparam logic [7:0]  SSP_STAT_ADDR = 8'h04;  // Status: sleep, order, drive, burst
   localparam int          SSP_CTRL_SLEEP = 0;
   localparam int          SSP_STAT_SLEEP = 0;
   localparam int          SSP_STAT_ORDER = 1;
   localparam int          SSP_STAT_DRIVE = 2;
   localparam int          SSP_STAT_CNT   = 4;
   localparam logic [1:0]  SSP_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  SSP_RESP_SLVERR = 2'h2;
   localparam logic [1:0]  SSP_STEP_ONE    = 2'h1;

   typedef enum logic [1:0] {
      SSP_ST_IDLE  = 2'b00,
      SSP_ST_READ  = 2'b01,
      SSP_ST_WRITE = 2'b10
   } ssp_state_t;

   // Pin bundle, passed through the two-stage synchroniser
   typedef struct packed {
      logic                  cqn;
      logic                  sleep;
      logic                  cs_a_n;
      logic                  cs_b;
      logic                  cs_c_n;
      logic                  adv;
      logic                  write_n;
      logic [SSP_LANES-1:0]  lane_n;
      logic [SSP_AW-1:0]     addr;
      logic [SSP_DW-1:0]     dq;
      logic [SSP_LANES-1:0]  par;
      logic                  mode;
   } ssp_pin_t;

   // One captured write beat
   typedef struct packed {
      logic [SSP_AW-1:0]     addr;
      logic [SSP_DW-1:0]     dq;
      logic [SSP_LANES-1:0]  par;
      logic [SSP_LANES-1:0]  lane_n;
   } ssp_wr_t;
endpackage

// *** logic/ssp_top.sv ***
// Data-port logic of a flow-through synchronous burst memory with AXI4-Lite status.
// Assumes pins come from outside the aclk domain; the output gate acts without the clock.
module ssp_top
   import ssp_pkg::*;
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  clock_qualify_n,
   input  wire logic                  sleep_request,
   input  wire logic                  chip_select_a_n,
   input  wire logic                  chip_select_b,
   input  wire logic                  chip_select_c_n,
   input  wire logic                  advance_or_load,
   input  wire logic                  write_n,
   input  wire logic [SSP_LANES-1:0]  byte_lane_write_n,
   input  wire logic [SSP_AW-1:0]     addr,
   input  wire logic                  output_gate_n,
   input  wire logic                  burst_order,
   input  wire logic [SSP_DW-1:0]     dq_in,
   output logic [SSP_DW-1:0]          dq_out,
   output logic [SSP_DW-1:0]          dq_oe,
   input  wire logic [SSP_LANES-1:0]  parity_lanes_in,
   output logic [SSP_LANES-1:0]       parity_lanes_out,
   output logic [SSP_LANES-1:0]       parity_lanes_oe,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   output logic [1:0]                 s_axi_bresp,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   input  wire logic [7:0]            s_axi_araddr,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp
);
   ssp_pin_t   raw, meta_q, pin_q;
   ssp_state_t state_q, state_d;
   logic [1:0] hi_q, hi_d, cnt_d, cnt_q;
   logic [SSP_DW+SSP_LANES-1:0] mem_q [SSP_DEPTH];
   logic [SSP_DW+SSP_LANES-1:0] mem_d [SSP_DEPTH];
   logic [SSP_DW-1:0]    rd_q, rd_d;
   logic [SSP_LANES-1:0] rp_q, rp_d, lane_we;
   logic       drive_q, drive_d, asleep_q, asleep_d, soft_sleep_q, soft_sleep_d;
   logic       en, load, sel, buf_in_ready, buf_out_valid, push, drain;
   ssp_wr_t    wr_beat, buf_out;
   logic [SSP_AW-1:0] addr_d;

   // Bundle the pins so one synchroniser covers them all
   always_comb begin
      raw         = '0;
      raw.cqn     = clock_qualify_n;
      raw.sleep   = sleep_request;
      raw.cs_a_n  = chip_select_a_n;
      raw.cs_b    = chip_select_b;
      raw.cs_c_n  = chip_select_c_n;
      raw.adv     = advance_or_load;
      raw.write_n = write_n;
      raw.lane_n  = byte_lane_write_n;
      raw.addr    = addr;
      raw.dq      = dq_in;
      raw.par     = parity_lanes_in;
      raw.mode    = burst_order;
   end

   // Two flops per pin; only pin_q is read by logic
   always_ff @(posedge aclk) begin
      meta_q <= raw;
      pin_q  <= meta_q;
   end

   // Sleep follows the pin or the soft bit; a full buffer also stalls the edge
   always_comb begin
      asleep_d = pin_q.sleep || soft_sleep_q;
      en       = !pin_q.cqn && !asleep_q && buf_in_ready;
      load     = !pin_q.adv;
      sel      = !pin_q.cs_a_n && pin_q.cs_b && !pin_q.cs_c_n;
   end

   ssp_burst u_burst (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .en          (en),
      .load        (load && sel),
      .advance     (!load && (state_q != SSP_ST_IDLE)),
      .start       (pin_q.addr[1:0]),
      .interleaved (pin_q.mode),
      .cnt_d       (cnt_d),
      .cnt_q       (cnt_q)
   );

   // Access pipeline: load, advance or hold; held state stretches the cycle
   always_comb begin
      state_d = state_q;
      hi_d    = hi_q;
      drive_d = drive_q;
      rd_d    = rd_q;
      rp_d    = rp_q;
      if (en) begin
         if (load && sel) begin
            state_d = pin_q.write_n ? SSP_ST_READ : SSP_ST_WRITE;
            hi_d    = pin_q.addr[3:2];
         end else if (load) begin
            state_d = SSP_ST_IDLE;                            // Deselect
         end
      end
      addr_d = {hi_d, cnt_d};
      if (en) begin
         // Only a read data cycle drives; write, deselect and idle stay off
         drive_d = (state_d == SSP_ST_READ);
         {rp_d, rd_d} = mem_q[addr_d];                        // Parity sits above data
      end
      if (asleep_q) drive_d = 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q  <= SSP_ST_IDLE;
         hi_q     <= 2'h0;
         drive_q  <= 1'b0;
         asleep_q <= 1'b0;
         rd_q     <= '0;
         rp_q     <= '0;
      end else begin
         state_q  <= state_d;
         hi_q     <= hi_d;
         drive_q  <= drive_d;
         asleep_q <= asleep_d;
         rd_q     <= rd_d;
         rp_q     <= rp_d;
      end
   end

   // Output drivers; the gate is combined without sampling so it acts at once
   always_comb begin
      dq_out           = rd_q;
      parity_lanes_out = rp_q;
      dq_oe            = {SSP_DW{drive_q && !output_gate_n}};
      parity_lanes_oe  = {SSP_LANES{drive_q && !output_gate_n}};
   end

   // Write data cycle: capture the input lines with their lane selects
   always_comb begin
      push           = en && (state_q == SSP_ST_WRITE);
      wr_beat.addr   = {hi_q, cnt_q};
      wr_beat.dq     = pin_q.dq;
      wr_beat.par    = pin_q.par;
      wr_beat.lane_n = pin_q.lane_n;
   end

   // The array stops taking words while asleep; any pending word waits in the buffer
   ssp_fifo2 #(.W($bits(ssp_wr_t))) u_wbuf (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_valid  (push),
      .in_ready  (buf_in_ready),
      .in_data   (wr_beat),
      .out_valid (buf_out_valid),
      .out_ready (!asleep_q),
      .out_data  (buf_out)
   );

   // Lane writes: data byte and its parity bit move together, selected lanes only
   assign drain = buf_out_valid && !asleep_q;
   for (genvar l = 0; l < SSP_LANES; l++) begin : g_lane
      assign lane_we[l] = drain && !buf_out.lane_n[l];
   end

   // One process owns the array, so per-lane writes cannot clash as drivers
   always_comb begin
      mem_d = mem_q;
      for (int l = 0; l < SSP_LANES; l++) begin
         if (lane_we[l]) begin
            mem_d[buf_out.addr][l*SSP_LANE_W +: SSP_LANE_W] = buf_out.dq[l*SSP_LANE_W +: SSP_LANE_W];
            mem_d[buf_out.addr][SSP_DW + l]                = buf_out.par[l];
         end
      end
   end

   // Array has no reset; contents stay undefined until written
   always_ff @(posedge aclk) begin
      mem_q <= mem_d;
   end

   // AXI4-Lite slave: soft sleep control and a status word
   logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [7:0]  awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d, rdata_d, stat;
   logic [3:0]  wstrb_q, wstrb_d;
   logic        awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
   logic [1:0]  bresp_d, rresp_d;

   always_comb begin
      aw_have_d    = aw_have_q;
      w_have_d     = w_have_q;
      awaddr_d     = awaddr_q;
      wdata_d      = wdata_q;
      wstrb_d      = wstrb_q;
      bvalid_d     = s_axi_bvalid;
      bresp_d      = s_axi_bresp;
      rvalid_d     = s_axi_rvalid;
      rdata_d      = s_axi_rdata;
      rresp_d      = s_axi_rresp;
      soft_sleep_d = soft_sleep_q;
      stat = '0;
      stat[SSP_STAT_SLEEP] = asleep_q;
      stat[SSP_STAT_ORDER] = pin_q.mode;
      stat[SSP_STAT_DRIVE] = drive_q;
      stat[SSP_STAT_CNT +: 2] = cnt_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_have_d = 1'b1;
         awaddr_d  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_have_d = 1'b1;
         wdata_d  = s_axi_wdata;
         wstrb_d  = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) bvalid_d = 1'b0;
      if (aw_have_q && w_have_q && !s_axi_bvalid) begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = SSP_RESP_OKAY;
         if (awaddr_q == SSP_CTRL_ADDR) begin
            if (wstrb_q[0]) soft_sleep_d = wdata_q[SSP_CTRL_SLEEP];
         end else if (awaddr_q != SSP_STAT_ADDR) begin
            bresp_d = SSP_RESP_SLVERR;                        // Unmapped
         end
      end
      if (s_axi_rvalid && s_axi_rready) rvalid_d = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rresp_d  = SSP_RESP_OKAY;
         rdata_d  = '0;
         if (s_axi_araddr == SSP_CTRL_ADDR) rdata_d[SSP_CTRL_SLEEP] = soft_sleep_q;
         else if (s_axi_araddr == SSP_STAT_ADDR) rdata_d = stat;
         else rresp_d = SSP_RESP_SLVERR;
      end
      // Ready is registered, so it looks one cycle ahead at the held state
      awready_d = !aw_have_d && !bvalid_d;
      wready_d  = !w_have_d && !bvalid_d;
      arready_d = !rvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         awaddr_q      <= '0;
         wdata_q       <= '0;
         wstrb_q       <= '0;
         soft_sleep_q  <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= SSP_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= SSP_RESP_OKAY;
      end else begin
         aw_have_q     <= aw_have_d;
         w_have_q      <= w_have_d;
         awaddr_q      <= awaddr_d;
         wdata_q       <= wdata_d;
         wstrb_q       <= wstrb_d;
         soft_sleep_q  <= soft_sleep_d;
         s_axi_awready <= awready_d;
         s_axi_wready  <= wready_d;
         s_axi_bvalid  <= bvalid_d;
         s_axi_bresp   <= bresp_d;
         s_axi_arready <= arready_d;
         s_axi_rvalid  <= rvalid_d;
         s_axi_rdata   <= rdata_d;
         s_axi_rresp   <= rresp_d;
      end
   end

   // Checks next to the logic they guard
   a_gate_drives: assert property (@(posedge aclk) disable iff (!aresetn)
      (drive_q && !output_gate_n) |-> (dq_oe == '1) && (parity_lanes_oe == '1))
      else $error("gate low with read data but lines not driven");
   a_gate_floats: assert property (@(posedge aclk) disable iff (!aresetn)
      output_gate_n |-> (dq_oe == '0) && (parity_lanes_oe == '0))
      else $error("lines driven while gate high");
   a_write_floats: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_q != SSP_ST_READ) |-> (dq_oe == '0))
      else $error("lines driven outside a read data cycle");
   a_qualify_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (!en && !asleep_q) |=> $stable(state_q) && $stable(hi_q) && $stable(rd_q) && $stable(cnt_q))
      else $error("state moved on an unqualified edge");
   a_sleep_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      asleep_q |=> !drive_q ##0 !push)
      else $error("activity while asleep");
   a_capture_beat: assert property (@(posedge aclk) disable iff (!aresetn)
      (en && state_q == SSP_ST_WRITE) |-> push && (wr_beat.dq == pin_q.dq))
      else $error("write beat not captured");
   a_flow_read: assert property (@(posedge aclk) disable iff (!aresetn)
      (en && state_d == SSP_ST_READ && !drain) |=> (rd_q == $past(mem_q[addr_d][SSP_DW-1:0])))
      else $error("read data not from the addressed word");
   a_lane_keep: assert property (@(posedge aclk) disable iff (!aresetn)
      (drain && buf_out.lane_n[0]) |=> (mem_q[$past(buf_out.addr)][SSP_DW] ==
                                         $past(mem_q[buf_out.addr][SSP_DW])))
      else $error("unselected parity lane changed");
endmodule
